// file: design/gpm_top.sv
// Port input sampling, edge interrupts and function one address routing.
// Assumes pins asynchronous to ref_clk_i, APB master on ref_clk_i, four 8-bit ports.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module gpm_top (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [31:0] pin_i,
    output logic [31:0] pin_o,
    output logic [31:0] pin_oe_o,
    input wire logic [15:0] ext_addr_i,
    input wire logic [31:0] periph_out_i,
    input wire logic [31:0] periph_oe_i,
    output logic [31:0] ext_data_pins_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] s1_r, s2_r, s3_r, samp_r;
    logic [31:0] dir_r, out_r, af1_r, esel_r, both_r, stat_r, mask_r;
    logic [3:0] exten_r;
    logic [31:0] rdat_r;
    logic [31:0] rise, fall, evt, ext_blk, wmask, af_eff, gpio_oe;
    logic wr_en, rd_en, hit;
    logic [31:0] rsel;

    // Change taken once stages two and three agree
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_r <= 32'h0;
            s2_r <= 32'h0;
            s3_r <= 32'h0;
            samp_r <= 32'h0;
        end else if (clk_en_i) begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            samp_r <= (s2_r & s3_r) | (samp_r & (s2_r | s3_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge events on the filtered samples
    assign rise = ~samp_r & s2_r & s3_r;
    assign fall = samp_r & ~s2_r & ~s3_r;
    assign evt = (both_r & (rise | fall))  | (~both_r & ((esel_r & rise) | (~esel_r & fall)));

    ////////////////////////////////////////////////////////////////////////
    genvar p;
    generate
        for (p = 0; p < gpm_pkg::NPORT; p++) begin : g_blk
            assign ext_blk[8*p +: 8] = {8{exten_r[p]}};
        end
    endgenerate
    assign ext_data_pins_o = ext_blk;
    assign af_eff = af1_r & ~ext_blk;
    assign gpio_oe = ~dir_r & ~af_eff & ~ext_blk;

    always_comb begin
        pin_o = out_r & ~ext_blk;
        pin_oe_o = gpio_oe;
        for (int i = 0; i < 32; i++) begin
            if (af_eff[i]) begin
                pin_o[i] = periph_out_i[i];
                pin_oe_o[i] = periph_oe_i[i];
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (af_eff[8*gpm_pkg::PORT_LOWADDR + i]) begin
                pin_o[8*gpm_pkg::PORT_LOWADDR + i] = ext_addr_i[i];
                pin_oe_o[8*gpm_pkg::PORT_LOWADDR + i] = 1'b1;
            end
            if (af_eff[8*gpm_pkg::PORT_MIDADDR + i]) begin
                pin_o[8*gpm_pkg::PORT_MIDADDR + i] = ext_addr_i[8 + i];
                pin_oe_o[8*gpm_pkg::PORT_MIDADDR + i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB: zero wait states, unmapped address answers pslverr
    assign wr_en = psel_i & penable_i & pwrite_i & clk_en_i;
    assign rd_en = psel_i & ~penable_i & ~pwrite_i & clk_en_i;
    assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign hit = (paddr_i[7:2] <= gpm_pkg::OFS_MASK[7:2]) && (paddr_i[1:0] == 2'b00);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o = rdat_r;

    always_comb begin
        case (paddr_i)
            gpm_pkg::OFS_SAMPLE0, 8'h04, 8'h08, 8'h0c: rsel = {24'h0, samp_r[8*paddr_i[3:2] +: 8]};
            gpm_pkg::OFS_DIR: rsel = dir_r;
            gpm_pkg::OFS_OUT: rsel = out_r;
            gpm_pkg::OFS_AF1: rsel = af1_r;
            gpm_pkg::OFS_EXTEN: rsel = {28'h0, exten_r};
            gpm_pkg::OFS_EDGESEL: rsel = esel_r;
            gpm_pkg::OFS_BOTHSEL: rsel = both_r;
            gpm_pkg::OFS_STATUS: rsel = stat_r;
            gpm_pkg::OFS_MASK: rsel = mask_r;
            default: rsel = 32'h0;
        endcase
    end

    // Writes to sample words fall through: no register there, so they change nothing
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dir_r <= gpm_pkg::DIR_RST;
            out_r <= gpm_pkg::ZERO_RST;
            af1_r <= gpm_pkg::ZERO_RST;
            exten_r <= 4'h0;
            esel_r <= gpm_pkg::ZERO_RST;
            both_r <= gpm_pkg::ZERO_RST;
            mask_r <= gpm_pkg::ZERO_RST;
            rdat_r <= 32'h0;
        end else if (clk_en_i) begin
            if (rd_en) rdat_r <= rsel;
            if (wr_en && paddr_i == gpm_pkg::OFS_DIR) dir_r <= (dir_r & ~wmask) | (pwdata_i & wmask);
            if (wr_en && paddr_i == gpm_pkg::OFS_OUT) out_r <= (out_r & ~wmask) | (pwdata_i & wmask);
            if (wr_en && paddr_i == gpm_pkg::OFS_AF1) af1_r <= (af1_r & ~wmask) | (pwdata_i & wmask);
            if (wr_en && paddr_i == gpm_pkg::OFS_EXTEN && pstrb_i[0]) exten_r <= pwdata_i[3:0];
            if (wr_en && paddr_i == gpm_pkg::OFS_EDGESEL) esel_r <= (esel_r & ~wmask) | (pwdata_i & wmask);
            if (wr_en && paddr_i == gpm_pkg::OFS_BOTHSEL) both_r <= (both_r & ~wmask) | (pwdata_i & wmask);
            if (wr_en && paddr_i == gpm_pkg::OFS_MASK) mask_r <= (mask_r & ~wmask) | (pwdata_i & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event beats a same-cycle clear
    logic [31:0] clr;
    assign clr = (wr_en && paddr_i == gpm_pkg::OFS_STATUS) ? (pwdata_i & wmask) : 32'h0;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stat_r <= gpm_pkg::ZERO_RST;
        end else if (clk_en_i) begin
            stat_r <= (stat_r & ~clr) | evt;
        end
    end
    assign irq_o = |(stat_r & mask_r);
endmodule

// file: design/gpm_pkg.sv
// Constants for the port input and pin function map block.
// Assumes one 100 MHz clock and an APB slave with 32-bit data.
// What this block does
// - With function one selected, low address port lines 0..7 carry address bits 0..7 in order.
// - With function one selected, mid address port lines 0..7 carry address bits 8..15 in order.
// - Some pins raise an interrupt on one configured edge, rising or falling.
// - Other interrupt pins raise an interrupt on every edge, rising and falling.
// - Reading a port's sample register returns the latest sampled pin values.
// - The sample register is read-only; writes change neither it nor any pin.
// - Sample bit n is pin n, one meaning high and zero meaning low.
// - A pin under an alternate function takes its direction from the peripheral on ports 0 and 1, and is always an output on address ports 2 and 3.
// - With external data enabled on a port, GPIO, alternate function and address drive of its pins is blocked; sampling and edge interrupts continue.
package gpm_pkg;
    localparam int NPORT = 4;
    // Word offsets (byte addresses)
    localparam logic [7:0] OFS_SAMPLE0 = 8'h00; // Four ports, one word apart
    localparam logic [7:0] OFS_DIR = 8'h10; // [8*p+n] per port
    localparam logic [7:0] OFS_OUT = 8'h14;
    localparam logic [7:0] OFS_AF1 = 8'h18;
    localparam logic [7:0] OFS_EXTEN = 8'h1c; // Bit p: external data on port p
    localparam logic [7:0] OFS_EDGESEL = 8'h20; // 1 = rising, for single-edge pins
    localparam logic [7:0] OFS_BOTHSEL = 8'h24; // 1 = pin fires on both edges
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_MASK = 8'h2c;
    localparam logic [31:0] DIR_RST = 32'hffff_ffff;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    localparam int PORT_LOWADDR = 2; // Port carrying address 7:0
    localparam int PORT_MIDADDR = 3; // Port carrying address 15:8
endpackage

// file: tb/gpm_pins.sv
// Devices on the port lines: one commanded level per line.
// Assumes the split pin_o/pin_oe_o outputs of the port block.
`timescale 1ns/1ps
module gpm_pins (
    input wire logic [31:0] drive_i,
    input wire logic [31:0] drive_en_i,
    input wire logic [31:0] ext_level_i,
    output logic [31:0] pin_level_o
);
    // No contention modelled: the port wins where it drives
    assign pin_level_o = (drive_i & drive_en_i) | (ext_level_i & ~drive_en_i);
endmodule

// file: tb/gpm_chk_chk.sv
// Port-level checks of the port block.
// Assumes all APB writes use every byte lane.
`timescale 1ns/1ps
module gpm_chk (
    input wire logic ref_clk_i, sys_rst_i, clk_en_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o,
    input wire logic [7:0] paddr_i,
    input wire logic [15:0] ext_addr_i,
    input wire logic [31:0] pwdata_i, pin_i, pin_o, pin_oe_o, periph_oe_i, ext_data_pins_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_acc;
        psel_i && penable_i && clk_en_i;
    endsequence
    logic [31:0] af1_r;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) af1_r <= 32'h0000_0000;
        else if (psel_i && penable_i && pwrite_i && clk_en_i && paddr_i == gpm_pkg::OFS_AF1) af1_r <= pwdata_i;
    end
    AST_READY: assert property (s_acc |-> pready_o) else $error("no ready");
    AST_UNMAPPED: assert property (s_acc ##0 paddr_i > 8'h2c |-> pslverr_o) else $error("no error");
    AST_RO_NOERR: assert property (s_acc ##0 paddr_i < 8'h10 |-> !pslverr_o) else $error("sample error");
    AST_LOWADDR: assert property (af1_r[23:16] == 8'hff && !ext_data_pins_o[16]
        |-> pin_o[23:16] == ext_addr_i[7:0] && pin_oe_o[23:16] == 8'hff) else $error("low address");
    AST_MIDADDR: assert property (af1_r[31:24] == 8'hff && !ext_data_pins_o[24]
        |-> pin_o[31:24] == ext_addr_i[15:8] && pin_oe_o[31:24] == 8'hff) else $error("mid address");
    AST_AF_DIR: assert property (af1_r[7:0] == 8'hff && !ext_data_pins_o[0]
        |-> pin_oe_o[7:0] == periph_oe_i[7:0]) else $error("af direction");
    AST_EXT_BLOCK: assert property (ext_data_pins_o != 32'h0 |-> (pin_oe_o & ext_data_pins_o) == 32'h0)
        else $error("ext not blocked");
    // Irq may only rise after a register write or a pin change 3 to 5 edges back
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(psel_i && penable_i && pwrite_i)
        || $past(pin_i, 3) != $past(pin_i, 4) || $past(pin_i, 4) != $past(pin_i, 5)
        || $past(pin_i, 5) != $past(pin_i, 6)) else $error("irq cause");
endmodule
bind gpm_top gpm_chk u_chk(.*);

// file: tb/test_gpm_top.sv
// Bench for the port block: APB tasks, pin stimulus, edge interrupts.
// Assumes gpm_pins drives the port lines.
`timescale 1ns/1ps
module test_gpm_top;
    logic ref_clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready_o, pslverr_o, irq_o, er;
    logic [7:0] paddr = 8'h00;
    logic [15:0] ext_addr = 16'h0000;
    logic [31:0] pwdata = 32'h0, drv = 32'ha53c_0f81, poe = 32'h0, rd, prdata_o, pin_i, pin_o, pin_oe_o, ext_d;
    logic [31:0] tog [4] = '{32'h1, 32'h2, 32'h2, 32'h1};
    logic [31:0] ex [4] = '{32'h0, 32'h2, 32'h2, 32'h1};
    int n_fail = 0, tests_run = 0, cyc = 0;
    initial forever #5 ref_clk_i = ~ref_clk_i;
    gpm_top u_dut(.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .ext_addr_i(ext_addr), .periph_out_i(32'h0000_00a5), .periph_oe_i(poe), .ext_data_pins_o(ext_d), .irq_o(irq_o));
    gpm_pins u_pins(.drive_i(pin_o), .drive_en_i(pin_oe_o), .ext_level_i(drv), .pin_level_o(pin_i));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk_i) penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Whole run is under 1000 cycles
    always @(posedge ref_clk_i) if (++cyc == 5000) begin
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rdchk("dir", gpm_pkg::OFS_DIR, gpm_pkg::DIR_RST);
        chk("irq", 32'h0, {31'h0, irq_o});
        for (int p = 0; p < 4; p++) rdchk("sample", 8'(4 * p), {24'h0, drv[8 * p +: 8]});
        apb(1'b1, 8'h04, 32'hffff_ffff);
        chk("ro err", 32'h0, {31'h0, er});
        rdchk("ro", 8'h04, {24'h0, drv[15:8]});
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        $display("test regs done");
        ext_addr <= 16'hbeef;
        poe <= 32'h0000_005a;
        apb(1'b1, gpm_pkg::OFS_AF1, 32'hffff_00ff);
        @(posedge ref_clk_i);
        chk("addr", 32'hbeef_0000, pin_o & 32'hffff_0000);
        chk("oe", 32'hffff_005a, pin_oe_o);
        apb(1'b1, gpm_pkg::OFS_EXTEN, 32'h4);
        @(posedge ref_clk_i);
        chk("ext", 32'h00ff_0000, ext_d);
        chk("ext oe", 32'hff00_005a, pin_oe_o);
        apb(1'b1, gpm_pkg::OFS_EXTEN, 32'h0);
        apb(1'b1, gpm_pkg::OFS_AF1, 32'h0);
        $display("test pins done");
        apb(1'b1, gpm_pkg::OFS_EDGESEL, 32'h1);
        apb(1'b1, gpm_pkg::OFS_BOTHSEL, 32'h2);
        apb(1'b1, gpm_pkg::OFS_MASK, 32'h3);
        apb(1'b1, gpm_pkg::OFS_STATUS, 32'hffff_ffff);
        for (int i = 0; i < 4; i++) begin
            drv <= drv ^ tog[i];
            repeat (8) @(posedge ref_clk_i);
            rdchk("status", gpm_pkg::OFS_STATUS, ex[i]);
            chk("irq", {31'h0, ex[i] != 32'h0}, {31'h0, irq_o});
            apb(1'b1, gpm_pkg::OFS_STATUS, ex[i]);
        end
        apb(1'b1, gpm_pkg::OFS_MASK, 32'h0);
        drv <= drv ^ 32'h2;
        repeat (8) @(posedge ref_clk_i);
        rdchk("masked", gpm_pkg::OFS_STATUS, 32'h2);
        chk("masked irq", 32'h0, {31'h0, irq_o});
        $display("test irq done");
        tally_and_finish();
    end
endmodule
